// [src/iowdt_pkg.sv]
package iowdt_pkg;
	localparam logic [15:0] PORT_ADDR = 16'h0443;
	localparam int ADDR_W = 16;
	localparam logic [7:0] TIMEOUT_MIN = 8'h01;
	localparam logic [7:0] TIMEOUT_MAX = 8'h3e;
	localparam logic [7:0] RST_INTERVAL = 8'h00;
	localparam int CLK_HZ = 100000000;
	localparam int TICK_MS = 1000;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
	localparam int EXPIRE_PULSE_CYCLES = 16;
	typedef enum logic [1:0]
	{
		IOWDT_IDLE = 2'b00,
		IOWDT_RUN = 2'b01,
		IOWDT_FIRED = 2'b10
	} iowdt_state_t;
endpackage : iowdt_pkg

// [src/iowdt_tick.sv]
module iowdt_tick #(
	parameter int TICK_CYCLES = iowdt_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic restart_i,
	output logic tick_o
);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	logic [CW-1:0] count;

	initial
	begin
		if (TICK_CYCLES < 2)
			$error("TICK_CYCLES must be at least 2");
	end

	// Restart realigns the second boundary to the write
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count <= '0;
			tick_o <= 1'b0;
		end
		else if (restart_i)
		begin
			count <= '0;
			tick_o <= 1'b0;
		end
		else if (count == CW'(TICK_CYCLES - 1))
		begin
			count <= '0;
			tick_o <= 1'b1;
		end
		else
		begin
			count <= count + CW'(1);
			tick_o <= 1'b0;
		end
	end
endmodule : iowdt_tick

// [src/iowdt_top.sv]
// What this block does
// - A nonzero byte write to port 0x443 loads the interval and starts countdown.
// - Byte 0x01..0x3e means 1..62 seconds, one second per count.
// - Each nonzero write while running restarts with the new interval.
// - A read of the port stops and disables the watchdog.
// - On expiry assert CPU reset or an interrupt request, as selected.
module iowdt_top #(
	parameter int TICK_CYCLES = iowdt_pkg::TICK_CYCLES,
	parameter int PULSE_CYCLES = iowdt_pkg::EXPIRE_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Host I/O port, one-cycle strobes
	input wire logic [iowdt_pkg::ADDR_W-1:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_rvalid_o,
	// Expiry response selection, 1 = interrupt, 0 = reset
	input wire logic resp_irq_sel_i,
	// Expiry outputs
	output logic cpu_reset_o,
	output logic irq_o,
	// Status
	output logic running_o
);
	initial
	begin
		if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255)
			$error("PULSE_CYCLES out of range");
		if (TICK_CYCLES < 2)
			$error("TICK_CYCLES must be at least 2");
		if (iowdt_pkg::TIMEOUT_MAX < iowdt_pkg::TIMEOUT_MIN)
			$error("Timeout limits reversed");
	end

	iowdt_pkg::iowdt_state_t state;
	logic [7:0] remaining;
	logic [7:0] interval;
	logic [7:0] pulse_cnt;
	logic sel_s1;
	logic sel_s2;
	logic resp_irq;
	logic tick;
	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic valid_val;
	logic acc_hit;
	logic [7:0] load_val;

	function automatic logic [7:0] clamp_interval(input logic [7:0] v);
		if (v > iowdt_pkg::TIMEOUT_MAX)
			return iowdt_pkg::TIMEOUT_MAX;
		return v;
	endfunction : clamp_interval

	// Expiry level, cut short by any access to the port
	function automatic logic expiry_level(
		input iowdt_pkg::iowdt_state_t s,
		input logic irq_mode,
		input logic want_irq,
		input logic access
	);
		return (s == iowdt_pkg::IOWDT_FIRED) && (irq_mode == want_irq)
			&& !access;
	endfunction : expiry_level

	// Port decode
	assign hit = (io_addr_i == iowdt_pkg::PORT_ADDR);
	assign acc_hit = wr_hit || rd_hit;
	assign wr_hit = hit && io_wr_i;
	assign rd_hit = hit && io_rd_i && !io_wr_i;
	assign valid_val = (io_wdata_i >= iowdt_pkg::TIMEOUT_MIN);
	assign load_val = clamp_interval(io_wdata_i);

	// Second tick, realigned on each write to the port, ignored zero writes included
	iowdt_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.restart_i(wr_hit),
		.tick_o(tick)
	);

	// Strap synchroniser
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
		end
		else
		begin
			sel_s1 <= resp_irq_sel_i;
			sel_s2 <= sel_s1;
		end
	end

	// Response latched while idle so it stays static during a countdown
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			resp_irq <= 1'b0;
		else if (state == iowdt_pkg::IOWDT_IDLE)
			resp_irq <= sel_s2;
	end

	// Countdown state
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= iowdt_pkg::IOWDT_IDLE;
			remaining <= iowdt_pkg::RST_INTERVAL;
			interval <= iowdt_pkg::RST_INTERVAL;
			pulse_cnt <= 8'h00;
		end
		else if (wr_hit && valid_val)
		begin
			// Write beats a read in the same cycle; zero is ignored
			state <= iowdt_pkg::IOWDT_RUN;
			remaining <= load_val;
			interval <= load_val;
			pulse_cnt <= 8'h00;
		end
		else if (rd_hit)
		begin
			state <= iowdt_pkg::IOWDT_IDLE;
			remaining <= iowdt_pkg::RST_INTERVAL;
			pulse_cnt <= 8'h00;
		end
		else
		begin
			case (state)
				iowdt_pkg::IOWDT_IDLE:
				begin
					pulse_cnt <= 8'h00;
				end
				iowdt_pkg::IOWDT_RUN:
				begin
					if (tick)
					begin
						if (remaining == 8'h01)
						begin
							state <= iowdt_pkg::IOWDT_FIRED;
							remaining <= 8'h00;
							pulse_cnt <= 8'(PULSE_CYCLES);
						end
						else
							remaining <= remaining - 8'h01;
					end
				end
				iowdt_pkg::IOWDT_FIRED:
				begin
					if (pulse_cnt == 8'h01)
						state <= iowdt_pkg::IOWDT_IDLE;
					pulse_cnt <= pulse_cnt - 8'h01;
				end
				default:
				begin
					state <= iowdt_pkg::IOWDT_IDLE;
				end
			endcase
		end
	end

	// CPU reset pulse
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cpu_reset_o <= 1'b0;
		else
			cpu_reset_o <= expiry_level(state, resp_irq, 1'b0,
				acc_hit);
	end

	// Interrupt request pulse
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= expiry_level(state, resp_irq, 1'b1,
				acc_hit);
	end

	// Running status, one cycle behind the state
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			running_o <= 1'b0;
		else
			running_o <= (state == iowdt_pkg::IOWDT_RUN);
	end

	// Read strobe answer, one cycle long
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			io_rvalid_o <= 1'b0;
		else
			io_rvalid_o <= rd_hit;
	end

	// Read data returns the remaining seconds
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			io_rdata_o <= 8'h00;
		else if (rd_hit)
			io_rdata_o <= remaining;
	end
endmodule : iowdt_top

// [verif/iowdt_top_asserts.sv]
module iowdt_top_asserts #(
	parameter int TICK_CYCLES = 4,
	parameter int PULSE_CYCLES = 3
) (
	// Watched ports
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic io_rvalid_o,
	input wire logic resp_irq_sel_i,
	input wire logic cpu_reset_o,
	input wire logic irq_o,
	input wire logic running_o
);
	localparam int HI = TICK_CYCLES + 3;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire hit = io_addr_i == iowdt_pkg::PORT_ADDR;
	wire wr = hit && io_wr_i && io_wdata_i != 8'h00;
	wire rd = hit && io_rd_i && !io_wr_i;
	wire fire = cpu_reset_o | irq_o;
	sequence calm3;
		!fire [*3];
	endsequence
	start_run_a: assert property (wr |-> ##[1:2] running_o)
		else $error("no run");
	one_sec_a: assert property (wr && io_wdata_i == 8'h01 |=>
		##1 calm3 ##[1:HI] fire) else $error("bad 1 s");
	restart_a: assert property (wr |=> ##1 calm3)
		else $error("no restart");
	read_stop_a: assert property (rd |=>
		io_rvalid_o ##[1:2] !running_o) else $error("no stop");
	rst_mode_a: assert property ($rose(cpu_reset_o) |->
		!resp_irq_sel_i) else $error("bad reset");
	irq_mode_a: assert property ($rose(irq_o) |->
		resp_irq_sel_i) else $error("bad irq");
	one_resp_a: assert property (irq_o |-> !cpu_reset_o)
		else $error("two responses");
endmodule : iowdt_top_asserts
bind iowdt_top iowdt_top_asserts #(.TICK_CYCLES(TICK_CYCLES),
	.PULSE_CYCLES(PULSE_CYCLES)) iowdt_top_asserts_i (.*);

// [verif/iowdt_host.sv]
module iowdt_host (
	// Clock
	input wire logic sys_clk_i,
	// Port access
	output logic [15:0] io_addr_o,
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [7:0] io_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		io_addr_o = 16'h0000;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		io_addr_o = a;
		io_wdata_o = d;
		io_wr_o = w;
		io_rd_o = !w;
		@(negedge sys_clk_i);
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		// Released lines show no stale value
		io_addr_o = ~a;
		io_wdata_o = ~d;
	endtask : acc
endmodule : iowdt_host

// [verif/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i, rst_n_i, io_wr_i, io_rd_i, io_rvalid_o, resp_irq_sel_i;
	logic cpu_reset_o, irq_o, running_o;
	logic [15:0] io_addr_i;
	logic [7:0] io_wdata_i, io_rdata_o;
	int mismatches, samples_checked, n;
	iowdt_host iowdt_host_i (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr_i),
		.io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i));
	iowdt_top #(.TICK_CYCLES(4), .PULSE_CYCLES(3)) iowdt_top_i (.*);
	task test_done();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task ck(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL %s exp %h got %h", s, e, g);
		end
	endtask : ck
	task wr(input logic [7:0] d);
		iowdt_host_i.acc(1'b1, 16'h0443, d);
	endtask : wr
	task rd();
		iowdt_host_i.acc(1'b0, 16'h0443, 8'h00);
	endtask : rd
	// Cycles until an expiry pulse shows
	task wt(input int lim);
		n = 0;
		while ((cpu_reset_o | irq_o) !== 1'b1 && n < lim)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		if (n >= lim)
		begin
			mismatches++;
			test_done();
		end
	endtask : wt
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		rst_n_i = 1'b0;
		resp_irq_sel_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		wr(8'h01);
		wt(20);
		ck("rst", 1, cpu_reset_o);
		ck("irq", 0, irq_o);
		wr(8'h3e);
		wt(300);
		ck("len", 1, n >= 245 && n <= 251);
		wr(8'h50);
		rd();
		ck("rvalid", 1, io_rvalid_o);
		ck("clamp", 8'h3e, io_rdata_o);
		repeat (3)
		begin
			wr(8'h02);
			repeat (5) @(negedge sys_clk_i);
		end
		ck("quiet", 0, cpu_reset_o);
		wr(8'h02);
		rd();
		ck("left", 8'h02, io_rdata_o);
		repeat (12) @(negedge sys_clk_i);
		ck("run", 0, running_o);
		ck("off", 0, cpu_reset_o);
		iowdt_host_i.acc(1'b1, 16'h0442, 8'h01);
		repeat (3) @(negedge sys_clk_i);
		ck("addr", 0, running_o);
		wr(8'h00);
		repeat (3) @(negedge sys_clk_i);
		ck("zero", 0, running_o);
		resp_irq_sel_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		wr(8'h01);
		wt(20);
		ck("irq", 1, irq_o);
		ck("rst", 0, cpu_reset_o);
		test_done();
	end
endmodule : testbench
